// [bench/fpsc_flash_power_state_control_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module fpsc_flash_power_state_control_properties #(
    parameter int WAKE_CYCLES = 20
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic o_data_oe,
    input wire logic o_standby,
    input wire logic o_deep_power,
    input wire logic o_lockout,
    input wire logic o_write_enable_latch,
    input wire logic [7:0] o_status,
    input wire logic o_cmd_valid
);
    // Counts from select rise while asleep
    int wait_q;
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_q <= 0;
        end
        else if (!o_deep_power || !i_cs_n)
        begin
            wait_q <= 0;
        end
        else
        begin
            wait_q <= wait_q + 1;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_idle;
        (o_standby && i_cs_n) ##1 i_cs_n ##1 i_cs_n;
    endsequence
    property p_idle;
        s_idle |-> o_standby;
    endproperty
    a_idle: assert property (p_idle) else $error("standby left");
    property p_leave;
        $fell(i_cs_n) && o_standby |-> ##[1:5] !o_standby;
    endproperty
    a_leave: assert property (p_leave) else $error("select ignored");
    property p_wake;
        $fell(o_deep_power) |-> wait_q >= WAKE_CYCLES && wait_q <= WAKE_CYCLES + 8;
    endproperty
    a_wake: assert property (p_wake) else $error("wake delay off");
    property p_cmd;
        o_cmd_valid |-> $past(i_cs_n, 3) && !$past(o_deep_power);
    endproperty
    a_cmd: assert property (p_cmd) else $error("bad command pulse");
    property p_lock_wel;
        o_lockout |-> !o_write_enable_latch;
    endproperty
    a_lock_wel: assert property (p_lock_wel) else $error("latch set in lockout");
    property p_lock_status;
        o_lockout |-> o_status == 8'h00;
    endproperty
    a_lock_status: assert property (p_lock_status) else $error("status moved");
    property p_deep_excl;
        o_deep_power |-> !o_standby;
    endproperty
    a_deep_excl: assert property (p_deep_excl) else $error("two states");
    property p_oe;
        o_data_oe |-> !i_cs_n;
    endproperty
    a_oe: assert property (p_oe) else $error("output while deselected");
endmodule
`default_nettype wire

// [bench/fpsc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpsc_host_model (
    input wire logic i_data,
    output logic o_spi_clk,
    output logic o_cs_n,
    output logic o_data_in
);
    initial
    begin
        o_spi_clk = 1'b0;
        o_cs_n = 1'b1;
        o_data_in = 1'b0;
    end
    // Clock stands still between frames
    task automatic frame(input logic [39:0] v, input int n, output logic [39:0] rx);
        rx = 40'h00_0000_0000;
        #5.3 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_data_in = v[n - 1 - i];
            #15 o_spi_clk = 1'b1;
            rx = {rx[38:0], i_data};
            #15 o_spi_clk = 1'b0;
        end
        #15 o_cs_n = 1'b1;
        o_data_in = ~o_data_in;
    endtask
endmodule
`default_nettype wire

// [bench/tb_flash_power_state_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_power_state_control;
    localparam int WAKE = 20;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic sclk, cs_n, din, dout, oe, stby, deep, lock, write_enable_latch, cmd_v;
    logic [7:0] status, cmd_op, cmd_dat;
    logic [39:0] rx;
    int err_count = 0;
    int n_tests = 0;
    always #2 i_clock = ~i_clock;
    fpsc_host_model host (.i_data(dout), .o_spi_clk(sclk), .o_cs_n(cs_n), .o_data_in(din));
    fpsc_flash_power_state_control #(.WAKE_CYCLES(WAKE), .LOCKOUT_CYCLES(1000),
        .SIGNATURE(8'h3C)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_clk(sclk),
        .i_cs_n(cs_n), .i_data_in(din), .o_data(dout), .o_data_oe(oe), .o_standby(stby),
        .o_deep_power(deep), .o_lockout(lock), .o_write_enable_latch(write_enable_latch),
        .o_status(status), .o_cmd_valid(cmd_v), .o_cmd_opcode(cmd_op), .o_cmd_data(cmd_dat));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_for(ref logic sig, input logic val, input int lim, output int cyc);
        cyc = 0;
        while (sig !== val)
        begin
            @(posedge i_clock);
            cyc++;
            if (cyc > lim)
            begin
                chk_bit(sig, val);
                final_report();
            end
        end
    endtask
    task automatic send(input logic [39:0] v, input int n);
        host.frame(v, n, rx);
        repeat (10) @(posedge i_clock);
    endtask
    task automatic t_power_up();
        chk_bit(stby, 1'b1);
        chk_bit(deep, 1'b0);
        chk_bit(write_enable_latch, 1'b0);
        chk(status, 8'h00);
        chk_bit(lock, 1'b1);
    endtask
    task automatic t_lockout();
        send(40'h06, 8);
        chk_bit(write_enable_latch, 1'b0);
        send(40'h01FF, 16);
        chk(status, 8'h00);
        send(40'h0355, 16);
        chk(cmd_op, 8'h03);
        chk(cmd_dat, 8'h55);
        send(40'hAB_0000_0000, 40);
        chk(rx[7:0], 8'h3C);
        chk_bit(stby, 1'b1);
        chk_bit(lock, 1'b1);
    endtask
    task automatic t_after_lockout();
        int cyc;
        wait_for(lock, 1'b0, 1200, cyc);
        send(40'h06, 8);
        chk_bit(write_enable_latch, 1'b1);
        send(40'h01C3, 16);
        chk(status, 8'hC3);
        chk(cmd_op, 8'h01);
        chk(cmd_dat, 8'hC3);
        chk_bit(write_enable_latch, 1'b0);
    endtask
    task automatic t_deep_wake();
        int cyc;
        send(40'hB9, 8);
        chk_bit(deep, 1'b1);
        send(40'h06, 8);
        chk_bit(write_enable_latch, 1'b0);
        host.frame(40'hAB, 8, rx);
        wait_for(stby, 1'b1, WAKE + 20, cyc);
        chk_bit(cyc >= WAKE, 1'b1);
        chk_bit(deep, 1'b0);
        send(40'h06, 8);
        chk_bit(write_enable_latch, 1'b1);
    endtask
    task automatic t_release_cut();
        int cyc;
        host.frame(40'hAB0, 12, rx);
        wait_for(stby, 1'b1, 8, cyc);
        repeat (10) @(posedge i_clock);
    endtask
    task automatic t_supply_drop();
        i_rst_n <= 1'b0;
        host.frame(40'h06, 8, rx);
        chk_bit(write_enable_latch, 1'b0);
        chk_bit(oe, 1'b0);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clock);
        t_power_up();
    endtask
    initial
    begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        t_power_up();
        t_lockout();
        t_after_lockout();
        t_deep_wake();
        t_release_cut();
        t_supply_drop();
        final_report();
    end
endmodule
bind fpsc_flash_power_state_control fpsc_flash_power_state_control_properties
    #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .o_data_oe(o_data_oe), .o_standby(o_standby),
    .o_deep_power(o_deep_power), .o_lockout(o_lockout),
    .o_write_enable_latch(o_write_enable_latch), .o_status(o_status),
    .o_cmd_valid(o_cmd_valid));
`default_nettype wire

// [rtl/fpsc_flash_power_state_control.sv]
`timescale 1ns/1ps
`default_nettype none
module fpsc_flash_power_state_control #(
    parameter int WAKE_CYCLES = fpsc_pkg::WAKE_CYCLES,
    parameter int LOCKOUT_CYCLES = fpsc_pkg::LOCKOUT_CYCLES,
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_WRITE_DISABLE = 8'h04,
    parameter logic [7:0] OP_STATUS_WRITE = 8'h01,
    parameter logic [7:0] OP_PAGE_PROGRAM = 8'h02,
    parameter logic [7:0] OP_SECTOR_ERASE = 8'hD8,
    parameter logic [7:0] OP_BULK_ERASE = 8'hC7,
    parameter logic [7:0] OP_DEEP_POWER = 8'hB9,
    parameter logic [7:0] OP_RELEASE = 8'hAB,
    // Arbitrary value, not a real part code
    parameter logic [7:0] SIGNATURE = 8'h5A
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_data_in,
    output logic o_data,
    output logic o_data_oe,
    output logic o_standby,
    output logic o_deep_power,
    output logic o_lockout,
    output logic o_write_enable_latch,
    output logic [7:0] o_status,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_opcode,
    output logic [7:0] o_cmd_data
);
    // Link side: count resets with each deselect, capture survives frames
    typedef struct packed {
        logic [5:0] cnt;
        logic [6:0] shift;
    } fpsc_frame_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data;
        logic op_tgl;
        logic dat_tgl;
    } fpsc_capture_t;
    typedef struct packed {
        logic [3:0] cs_s;
        logic [2:0] op_s;
        logic [2:0] dat_s;
        logic op_new;
        logic dat_new;
        fpsc_pkg::fpsc_state_t state;
        logic [17:0] lock_cnt;
        logic lock_done;
        logic [12:0] wake_cnt;
        logic write_enable_latch;
        logic [7:0] status;
        logic cmd_valid;
        logic [7:0] cmd_op;
        logic [7:0] cmd_data;
    } fpsc_core_t;

    fpsc_frame_t frame_q, frame_d;
    fpsc_capture_t cap_q, cap_d;
    fpsc_core_t core_q, core_d;
    logic out_bit_q;
    logic out_en_q;
    logic frame_rst_n;

    // Deselect ends the frame even though the link clock has stopped
    assign frame_rst_n = i_rst_n & ~i_cs_n;

    always_comb
    begin
        frame_d = frame_q;
        cap_d = cap_q;
        frame_d.shift = {frame_q.shift[5:0], i_data_in};
        if (frame_q.cnt == fpsc_pkg::SIG_LAST)
        begin
            frame_d.cnt = fpsc_pkg::SIG_FIRST; // Signature repeats while clocked
        end
        else
        begin
            frame_d.cnt = frame_q.cnt + 6'h01;
        end
        if (frame_q.cnt == fpsc_pkg::BYTE0_LAST)
        begin
            cap_d.opcode = {frame_q.shift, i_data_in};
            cap_d.op_tgl = ~cap_q.op_tgl;
        end
        if (frame_q.cnt == fpsc_pkg::BYTE1_LAST)
        begin
            cap_d.data = {frame_q.shift, i_data_in};
            cap_d.dat_tgl = ~cap_q.dat_tgl;
        end
    end

    always_ff @(posedge i_spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            frame_q <= '0;
        end
        else
        begin
            frame_q <= frame_d;
        end
    end

    always_ff @(posedge i_spi_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cap_q <= '0;
        end
        else
        begin
            cap_q <= cap_d;
        end
    end

    // Signature shifts on the falling edge after the three dummy bytes
    always_ff @(negedge i_spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            out_bit_q <= 1'b0;
            out_en_q <= 1'b0;
        end
        else
        begin
            out_en_q <= (frame_q.cnt >= fpsc_pkg::SIG_FIRST) && (cap_q.opcode == OP_RELEASE);
            out_bit_q <= SIGNATURE[~frame_q.cnt[2:0]];
        end
    end

    assign o_data = out_bit_q;
    assign o_data_oe = out_en_q & ~i_cs_n & i_rst_n;

    function automatic logic is_guarded(input logic [7:0] op);
        is_guarded = (op == OP_WRITE_ENABLE) || (op == OP_STATUS_WRITE)
            || (op == OP_PAGE_PROGRAM) || (op == OP_SECTOR_ERASE) || (op == OP_BULK_ERASE);
    endfunction

    logic cs_fall;
    logic cs_rise;

    always_comb
    begin
        core_d = core_q;
        core_d.cmd_valid = 1'b0;
        core_d.cs_s = {core_q.cs_s[2:0], i_cs_n};
        core_d.op_s = {core_q.op_s[1:0], cap_q.op_tgl};
        core_d.dat_s = {core_q.dat_s[1:0], cap_q.dat_tgl};
        // Rise taken one stage later so the toggles have landed first
        cs_fall = core_q.cs_s[2] & ~core_q.cs_s[1];
        cs_rise = core_q.cs_s[2] & ~core_q.cs_s[3];
        if (core_q.op_s[2] != core_q.op_s[1])
        begin
            core_d.op_new = 1'b1;
        end
        if (core_q.dat_s[2] != core_q.dat_s[1])
        begin
            core_d.dat_new = 1'b1;
        end
        if (cs_fall)
        begin
            core_d.op_new = 1'b0;
            core_d.dat_new = 1'b0;
        end
        if (core_q.lock_cnt == 18'(LOCKOUT_CYCLES - 1))
        begin
            core_d.lock_done = 1'b1;
        end
        else
        begin
            core_d.lock_cnt = core_q.lock_cnt + 18'h00001;
        end
        case (core_q.state)
            fpsc_pkg::PS_STANDBY:
            begin
                if (cs_fall)
                begin
                    core_d.state = fpsc_pkg::PS_ACTIVE;
                end
            end
            fpsc_pkg::PS_ACTIVE:
            begin
                if (cs_rise)
                begin
                    core_d.state = fpsc_pkg::PS_STANDBY;
                    if (core_q.op_new)
                    begin
                        if (cap_q.opcode == OP_DEEP_POWER)
                        begin
                            core_d.state = fpsc_pkg::PS_DEEP;
                        end
                        else if (is_guarded(cap_q.opcode) && !core_q.lock_done)
                        begin
                            core_d.write_enable_latch = core_q.write_enable_latch;
                        end
                        else if (cap_q.opcode == OP_WRITE_ENABLE)
                        begin
                            core_d.write_enable_latch = 1'b1;
                        end
                        else if (cap_q.opcode == OP_WRITE_DISABLE)
                        begin
                            core_d.write_enable_latch = 1'b0;
                        end
                        else if (is_guarded(cap_q.opcode))
                        begin
                            if (core_q.write_enable_latch && (core_q.dat_new || cap_q.opcode != OP_STATUS_WRITE))
                            begin
                                core_d.write_enable_latch = 1'b0;
                                core_d.cmd_valid = 1'b1;
                                core_d.cmd_op = cap_q.opcode;
                                core_d.cmd_data = cap_q.data;
                                if (cap_q.opcode == OP_STATUS_WRITE)
                                begin
                                    core_d.status = cap_q.data;
                                end
                            end
                        end
                        else if (cap_q.opcode != OP_RELEASE)
                        begin
                            core_d.cmd_valid = 1'b1;
                            core_d.cmd_op = cap_q.opcode;
                            core_d.cmd_data = cap_q.data;
                        end
                    end
                end
            end
            fpsc_pkg::PS_DEEP:
            begin
                if (cs_rise && core_q.op_new && cap_q.opcode == OP_RELEASE)
                begin
                    core_d.state = fpsc_pkg::PS_WAKING;
                    core_d.wake_cnt = '0;
                end
            end
            fpsc_pkg::PS_WAKING:
            begin
                // Select must stay high here; a frame now is not decoded
                if (core_q.wake_cnt == 13'(WAKE_CYCLES - 1))
                begin
                    core_d.state = fpsc_pkg::PS_STANDBY;
                end
                else
                begin
                    core_d.wake_cnt = core_q.wake_cnt + 13'h0001;
                end
            end
            default:
            begin
                core_d.state = fpsc_pkg::PS_STANDBY;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            core_q <= '0;
            core_q.cs_s <= 4'hF;
            core_q.state <= fpsc_pkg::PS_STANDBY;
            core_q.status <= fpsc_pkg::STATUS_RESET;
        end
        else
        begin
            core_q <= core_d;
        end
    end

    assign o_standby = (core_q.state == fpsc_pkg::PS_STANDBY);
    assign o_deep_power = (core_q.state == fpsc_pkg::PS_DEEP) || (core_q.state == fpsc_pkg::PS_WAKING);
    assign o_lockout = ~core_q.lock_done;
    assign o_write_enable_latch = core_q.write_enable_latch;
    assign o_status = core_q.status;
    assign o_cmd_valid = core_q.cmd_valid;
    assign o_cmd_opcode = core_q.cmd_op;
    assign o_cmd_data = core_q.cmd_data;
endmodule
`default_nettype wire

// [rtl/fpsc_pkg.sv]
// Notes on behaviour
// - Raising select after a full release byte still leads to standby, signature unfinished.
// - Release outside deep low-power enters standby at once on select high.
// - Release from deep low-power waits the wake delay; host keeps select high.
// - In standby, a new instruction is taken only after select goes low.
// - Below the write-inhibit threshold logic is held reset and nothing answers.
// - Write, program, erase and status-write are ignored during the write lockout delay.
// - Read instructions are taken while the write lockout is still running.
// - After power-up the device is in standby with the write enable latch clear.
// - On supply loss below threshold all operations stop and nothing answers.
// - Delivered array bytes read FFh; status register holds 00h.
// - In deep low-power every instruction except release is ignored.
// - The wake delay after select high is at most 30 microseconds; the code takes 7500 cycles plus up to 4 for select sync.
package fpsc_pkg;
    localparam int CLOCK_MHZ = 250;
    localparam int WAKE_DELAY_US = 30;
    localparam int WRITE_LOCKOUT_MS = 1;
    localparam int SELECT_AFTER_SUPPLY_US = 10;
    // Longest time, so whole cycles rounded down
    localparam int WAKE_CYCLES = WAKE_DELAY_US * CLOCK_MHZ;
    // Least time; exact at this rate
    localparam int LOCKOUT_CYCLES = WRITE_LOCKOUT_MS * 1000 * CLOCK_MHZ;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [5:0] BYTE0_LAST = 6'h07;
    localparam logic [5:0] BYTE1_LAST = 6'h0F;
    localparam logic [5:0] SIG_FIRST = 6'h20;
    localparam logic [5:0] SIG_LAST = 6'h27;
    typedef enum logic [1:0] {PS_STANDBY, PS_ACTIVE, PS_DEEP, PS_WAKING} fpsc_state_t;
endpackage
